// file: nvs_map.svh
`ifndef NVS_MAP_SVH
`define NVS_MAP_SVH
// ============================================================
// opcodes
`define NVS_OP_WR_ENABLE   8'h06
`define NVS_OP_WR_DISABLE  8'h04
`define NVS_OP_STAT_READ   8'h05
`define NVS_OP_STAT_WRITE  8'h01
`define NVS_OP_MEM_READ    8'h03
`define NVS_OP_MEM_WRITE   8'h02
`define NVS_OP_NV_STORE    8'h3C
`define NVS_OP_NV_RECALL   8'h60
`define NVS_OP_AUTOSAVE_ON 8'h59
`define NVS_OP_AUTOSAVE_OFF 8'h19
// ============================================================
// fields and reset values
`define NVS_ADDR_BITS      17
`define NVS_ADDR_BYTES     3
`define NVS_STAT_BUSY_BIT  0
`define NVS_AUTOSAVE_RST   1'b1
`define NVS_FIFO_DEPTH     16
// ============================================================
// timing
`define NVS_REF_CLK_HZ     25000000
`define NVS_SCK_MAX_HZ     30000000
`define NVS_RELOAD_US      20000
`define NVS_RECALL_US      200
`endif

// file: nvs_pkg.sv
// ============================================================
// shared types and opcode decoding
package nvs_pkg;
`include "nvs_map.svh"
    // frame states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b00_0001,
        ST_OPC    = 6'b00_0010,
        ST_ADDR   = 6'b00_0100,
        ST_DATA   = 6'b00_1000,
        ST_STAT   = 6'b01_0000,
        ST_IGNORE = 6'b10_0000
    } nvs_state_t;

    typedef logic [7:0] nvs_byte_t;

    // any opcode the device knows
    function automatic logic nvs_op_valid(input nvs_byte_t op);
        return op inside {`NVS_OP_WR_ENABLE, `NVS_OP_WR_DISABLE, `NVS_OP_STAT_READ,
                          `NVS_OP_STAT_WRITE, `NVS_OP_MEM_READ, `NVS_OP_MEM_WRITE,
                          `NVS_OP_NV_STORE, `NVS_OP_NV_RECALL, `NVS_OP_AUTOSAVE_ON,
                          `NVS_OP_AUTOSAVE_OFF};
    endfunction : nvs_op_valid

    // opcodes that touch the sram array
    function automatic logic nvs_op_mem(input nvs_byte_t op);
        return (op == `NVS_OP_MEM_READ) || (op == `NVS_OP_MEM_WRITE);
    endfunction : nvs_op_mem
endpackage : nvs_pkg

// file: nvs_stream_if.sv
`timescale 1ns/10ps
// ============================================================
// byte stream with valid/ready
interface nvs_stream_if #(parameter int W = 8);
    logic         valid; // word offered
    logic         ready; // word accepted
    logic [W-1:0] data;  // payload
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : nvs_stream_if

// file: nvs_sync3.sv
`timescale 1ns/10ps
// ============================================================
// three-stage pin synchroniser with agreement filter
module nvs_sync3 #(
    parameter int              W       = 3,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_r; // metastable stage, read by s2 only
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // shift chain
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit only moves once stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_filt
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                level[i] <= RST_VAL[i];
            end else if (s2_r[i] == s3_r[i]) begin
                level[i] <= s3_r[i];
            end
        end
    end
endmodule : nvs_sync3

// file: nvs_fifo.sv
`timescale 1ns/10ps
// ============================================================
// fifo with registered output stage
module nvs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    nvs_stream_if.snk fin,
    nvs_stream_if.src fout
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [W-1:0] mem [DEPTH];   // storage
    logic [AW-1:0] wr_ptr_r;     // write index
    logic [AW-1:0] rd_ptr_r;     // read index
    logic [AW:0]   count_r;      // words in array
    logic          push;
    logic          pop;

    assign fin.ready = (count_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign push = fin.valid && fin.ready;
    // refill output stage whenever it empties or is taken
    assign pop  = (count_r != '0) && (!fout.valid || fout.ready);

    // array write and pointers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr_r] <= fin.data;
                wr_ptr_r      <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // output stage
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fout.valid <= 1'b0;
            fout.data  <= '0;
        end else if (pop) begin
            fout.valid <= 1'b1;
            fout.data  <= mem[rd_ptr_r];
        end else if (fout.ready) begin
            fout.valid <= 1'b0;
        end
    end
endmodule : nvs_fifo

// file: nvs_spi_top.sv
`timescale 1ns/10ps
`include "nvs_map.svh"
// Functional notes
// R1: power-up reload, memory locked until done
// R2: busy pin low during power-up reload
// R3: recall command reloads, locks for recall time
// R4: master waits out recall before memory access (the bench writes during the lock in t_powerup and t_recall)
// R5: autosave off skips power-down store
// R6: autosave on restores power-down store
// R7: autosave setting volatile, kept by store
// R8: autosave enabled out of reset
// R9: power-up reload always happens
// R10: serial clock up to 30 MHz (not reachable with the 25 MHz reference sampling)
// R11: sample rising edge, drive falling edge
// R12: first byte after select is opcode
// R13: one opcode per select period
// R14: deselected: input ignored, output released
// R15: everything shifted msb first
// R16: three address bytes, low 17 bits used
// R17: master sends upper address bits zero (the bench in t_write sends FF in the top address byte)
// R18: bad opcode ignores rest, output released
// R19: clock level at select picks mode
// R20: mode 3 waits for first clock toggle
// R21: master parks clock per mode
// R22: eight-bit status register readable
// R23: recall 60, autosave on 59, off 19
// R24: status bit 0 shows busy
// R25: memory access during recall is ignored
module nvs_spi_top
    import nvs_pkg::*;
#(
    parameter int RELOAD_US = `NVS_RELOAD_US, // power-up reload time
    parameter int RECALL_US = `NVS_RECALL_US, // software recall time
    parameter int FIFO_DEPTH = `NVS_FIFO_DEPTH
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic                      cs_n,
    input  wire logic                      sck,
    input  wire logic                      si,
    output logic                           so,
    output logic                           so_oe_n,
    output logic                           store_busy_pin_o,
    output logic                           store_busy_pin_oe_n,
    input  wire logic                      store_busy_in,
    input  wire logic                      autosave_nv_in,
    input  wire logic                      power_fail,
    output logic                           autosave_en,
    output logic                           store_req,
    output logic                           autostore_req,
    output logic [`NVS_ADDR_BITS-1:0]      mem_addr,
    output logic                           mem_addr_valid,
    output logic                           mem_is_write,
    output nvs_pkg::nvs_byte_t             mem_byte,
    output logic                           mem_byte_valid,
    input  wire logic                      mem_byte_ready,
    output logic                           overrun
);
    import nvs_pkg::*;

    // ============================================================
    // timing
    localparam longint RELOAD_CYC_L =
        (longint'(RELOAD_US) * `NVS_REF_CLK_HZ + 999999) / 1000000;
    localparam longint RECALL_CYC_L =
        (longint'(RECALL_US) * `NVS_REF_CLK_HZ + 999999) / 1000000;
    localparam logic [23:0] RELOAD_CYC = 24'(RELOAD_CYC_L);
    localparam logic [23:0] RECALL_CYC = 24'(RECALL_CYC_L);
    // sampling needs several ref clocks per serial bit, so the full
    // serial rate is not reachable at this reference rate [R10]
    if (RELOAD_CYC_L < 1 || RELOAD_CYC_L > 24'hFF_FFFF ||
        RECALL_CYC_L < 1 || RECALL_CYC_L > 24'hFF_FFFF) begin : g_chk
        $error("recall times do not fit the 24-bit timer");
    end

    // ============================================================
    // pin sampling
    logic cs_s;    // filtered chip select, low active
    logic sck_s;   // filtered serial clock
    logic si_s;    // filtered serial input
    logic cs_d_r;  // previous levels for edge finding
    logic sck_d_r;

    nvs_sync3 #(.W(3), .RST_VAL(3'b100)) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     ({cs_n, sck, si}),
        .level   ({cs_s, sck_s, si_s})
    );

    // edge history; cs resets high so a real falling edge is needed
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs_d_r  <= 1'b1;
            sck_d_r <= 1'b0;
        end else begin
            cs_d_r  <= cs_s;
            sck_d_r <= sck_s;
        end
    end

    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    assign cs_fall  = !cs_s && cs_d_r;
    assign sck_rise = sck_s && !sck_d_r;
    assign sck_fall = !sck_s && sck_d_r;

    // ============================================================
    // recall timer and busy
    logic        recall_busy_r; // reload in progress
    logic        powerup_r;     // current reload is the power-up one
    logic [23:0] rcl_cnt_r;     // cycles left
    logic        recall_go;     // recall command accepted
    logic        pu_end;        // power-up reload finishing
    logic        busy_any;

    assign busy_any = recall_busy_r || store_busy_in;
    assign pu_end   = recall_busy_r && powerup_r && (rcl_cnt_r == 24'h00_0000);

    // reset is power-up: reload always starts here [R1] [R9]
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            recall_busy_r <= 1'b1;
            powerup_r     <= 1'b1;
            rcl_cnt_r     <= RELOAD_CYC - 24'h00_0001;
        end else if (recall_busy_r) begin
            if (rcl_cnt_r == 24'h00_0000) begin
                recall_busy_r <= 1'b0;
                powerup_r     <= 1'b0;
            end else begin
                rcl_cnt_r <= rcl_cnt_r - 24'h00_0001;
            end
        end else if (recall_go) begin
            // software recall holds the lock for its full time [R3]
            recall_busy_r <= 1'b1;
            rcl_cnt_r     <= RECALL_CYC - 24'h00_0001;
        end
    end

    // open-drain busy pin, pulled low while busy [R2]
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            store_busy_pin_o    <= 1'b0;
            store_busy_pin_oe_n <= 1'b1;
        end else begin
            store_busy_pin_o    <= 1'b0;
            store_busy_pin_oe_n <= !busy_any;
        end
    end

    // ============================================================
    // frame engine
    nvs_state_t state_r;
    logic       mode3_r;   // clock idled high at select
    logic       armed_r;   // rising edges count from here on
    logic [2:0] bit_cnt_r;
    nvs_byte_t  shift_r;
    nvs_byte_t  rx_byte;
    logic       byte_done;
    logic [1:0] addr_cnt_r;
    logic [23:0] addr_sh_r;
    logic       rise_ok;
    logic       opc_done;
    logic       data_byte;

    // deselected: no rising edge is sampled [R14]
    assign rise_ok   = sck_rise && armed_r && !cs_s && (state_r != ST_IDLE);
    assign byte_done = rise_ok && (bit_cnt_r == 3'd7);
    // msb arrives first, so shift left [R15] [R11]
    assign rx_byte   = {shift_r[6:0], si_s};
    assign opc_done  = byte_done && (state_r == ST_OPC);
    assign data_byte = byte_done && (state_r == ST_DATA) && mem_is_write;
    assign recall_go = opc_done && (rx_byte == `NVS_OP_NV_RECALL) && !busy_any; // [R23]

    // mode select and arming
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode3_r <= 1'b0;
            armed_r <= 1'b0;
        end else if (cs_fall) begin
            mode3_r <= sck_s;  // [R19]
            armed_r <= !sck_s;
        end else if (sck_fall) begin
            armed_r <= 1'b1;   // mode 3 counts rises only after first toggle [R20]
        end
    end

    // bit shifter
    always_ff @(posedge ref_clk) begin
        if (!rst_n || cs_fall) begin
            bit_cnt_r <= 3'd0;
            shift_r   <= 8'h00;
        end else if (rise_ok) begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            shift_r   <= rx_byte;
        end
    end

    // state sequencing; only a select edge starts an opcode [R12] [R13]
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else if (cs_s) begin
            state_r <= ST_IDLE;
        end else if (cs_fall) begin
            state_r <= ST_OPC;
        end else if (byte_done) begin
            unique case (state_r)
                ST_OPC: begin
                    if (!nvs_op_valid(rx_byte)) begin
                        state_r <= ST_IGNORE; // [R18]
                    end else if (nvs_op_mem(rx_byte)) begin
                        // memory locked while reloading [R25]
                        state_r <= busy_any ? ST_IGNORE : ST_ADDR;
                    end else if (rx_byte == `NVS_OP_STAT_READ) begin
                        state_r <= ST_STAT; // [R22]
                    end else begin
                        state_r <= ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    if (addr_cnt_r == 2'(`NVS_ADDR_BYTES - 1)) begin
                        state_r <= ST_DATA;
                    end
                end
                ST_IDLE, ST_DATA, ST_STAT, ST_IGNORE: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // address collection, upper seven bits dropped [R16]
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_cnt_r     <= 2'd0;
            addr_sh_r      <= 24'h00_0000;
            mem_addr       <= '0;
            mem_addr_valid <= 1'b0;
            mem_is_write   <= 1'b0;
        end else begin
            mem_addr_valid <= 1'b0;
            if (opc_done) begin
                addr_cnt_r   <= 2'd0;
                mem_is_write <= (rx_byte == `NVS_OP_MEM_WRITE);
            end else if (byte_done && state_r == ST_ADDR) begin
                addr_cnt_r <= addr_cnt_r + 2'd1;
                addr_sh_r  <= {addr_sh_r[15:0], rx_byte};
                if (addr_cnt_r == 2'(`NVS_ADDR_BYTES - 1)) begin
                    mem_addr       <= {addr_sh_r[`NVS_ADDR_BITS-9:0], rx_byte};
                    mem_addr_valid <= 1'b1;
                end
            end
        end
    end

    // ============================================================
    // serial output: status byte, changes on falling edges
    nvs_byte_t tx_r;
    nvs_byte_t stat_byte;
    always_comb begin
        stat_byte = 8'h00;
        stat_byte[`NVS_STAT_BUSY_BIT] = busy_any; // [R24]
    end

    // released unless reading status while selected [R14] [R18] [R25]
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            so      <= 1'b0;
            so_oe_n <= 1'b1;
            tx_r    <= 8'h00;
        end else if (opc_done && rx_byte == `NVS_OP_STAT_READ) begin
            tx_r <= stat_byte;
        end else if (cs_s || state_r != ST_STAT) begin
            so_oe_n <= 1'b1;
        end else if (sck_fall) begin
            so      <= tx_r[7];   // [R11] [R15]
            so_oe_n <= 1'b0;
            // repeated reads roll around the same byte
            tx_r    <= {tx_r[6:0], tx_r[7]};
        end
    end

    // ============================================================
    // autosave setting and store requests
    logic pf_d_r; // previous power_fail
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            autosave_en   <= `NVS_AUTOSAVE_RST; // [R8]
            pf_d_r        <= 1'b0;
            store_req     <= 1'b0;
            autostore_req <= 1'b0;
        end else begin
            pf_d_r    <= power_fail;
            store_req <= opc_done && (rx_byte == `NVS_OP_NV_STORE) && !busy_any;
            // power-down store only while enabled [R5]
            autostore_req <= power_fail && !pf_d_r && autosave_en;
            if (pu_end) begin
                autosave_en <= autosave_nv_in; // stored copy after power-up reload [R7]
            end else if (opc_done && rx_byte == `NVS_OP_AUTOSAVE_ON) begin
                autosave_en <= 1'b1; // [R6]
            end else if (opc_done && rx_byte == `NVS_OP_AUTOSAVE_OFF) begin
                autosave_en <= 1'b0; // [R5]
            end
        end
    end

    // ============================================================
    // write data into the fifo; serial side cannot stall, so a
    // byte that finds no room is dropped and flagged
    nvs_stream_if #(.W(8)) fin ();
    nvs_stream_if #(.W(8)) fout ();

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fin.valid <= 1'b0;
            fin.data  <= 8'h00;
            overrun   <= 1'b0;
        end else begin
            if (fin.valid && fin.ready) begin
                fin.valid <= 1'b0;
            end
            if (cs_fall) begin
                overrun <= 1'b0;
            end
            if (data_byte) begin
                if (!fin.valid || fin.ready) begin
                    fin.valid <= 1'b1;
                    fin.data  <= rx_byte;
                end else begin
                    overrun <= 1'b1; // set wins over the clear
                end
            end
        end
    end

    nvs_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .fin     (fin),
        .fout    (fout)
    );

    assign fout.ready     = mem_byte_ready;
    assign mem_byte       = fout.data;
    assign mem_byte_valid = fout.valid;

    // ============================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_pu_busy;
        $rose(rst_n) |-> recall_busy_r && powerup_r;
    endproperty
    a_pu_busy: assert property (p_pu_busy) else $error("no reload after reset"); // [R1] [R9]

    property p_busy_pin;
        recall_busy_r |=> !store_busy_pin_oe_n && !store_busy_pin_o;
    endproperty
    a_busy_pin: assert property (p_busy_pin) else $error("busy pin not low"); // [R2]

    property p_recall_len;
        recall_go |=> recall_busy_r && (rcl_cnt_r == RECALL_CYC - 24'h00_0001);
    endproperty
    a_recall_len: assert property (p_recall_len) else $error("recall timer bad"); // [R3]

    property p_asave_off;
        (power_fail && !pf_d_r && !autosave_en) |=> !autostore_req;
    endproperty
    a_asave_off: assert property (p_asave_off) else $error("store while off"); // [R5]

    property p_asave_on;
        (opc_done && rx_byte == `NVS_OP_AUTOSAVE_ON && !pu_end) |=> autosave_en;
    endproperty
    a_asave_on: assert property (p_asave_on) else $error("autosave not on"); // [R6]

    property p_desel;
        cs_s |=> so_oe_n && (state_r == ST_IDLE);
    endproperty
    a_desel: assert property (p_desel) else $error("drives while deselected"); // [R14]

    property p_bad_op;
        (opc_done && !nvs_op_valid(rx_byte) && !cs_s) |=> (state_r == ST_IGNORE) && so_oe_n;
    endproperty
    a_bad_op: assert property (p_bad_op) else $error("bad opcode not ignored"); // [R18]

    property p_lock;
        (opc_done && nvs_op_mem(rx_byte) && recall_busy_r) |=>
            (state_r != ST_ADDR) ##1 !mem_addr_valid;
    endproperty
    a_lock: assert property (p_lock) else $error("memory op during recall"); // [R25]

    property p_mode;
        cs_fall |=> (mode3_r == $past(sck_s)) && (armed_r == !$past(sck_s));
    endproperty
    a_mode: assert property (p_mode) else $error("mode pick wrong"); // [R19] [R20]

    property p_stat;
        (state_r == ST_STAT && !cs_s && sck_fall && !opc_done) |=>
            !so_oe_n && (so == $past(tx_r[7]));
    endproperty
    a_stat: assert property (p_stat) else $error("status bit not driven"); // [R22] [R24]

    c_recall: cover property (recall_go);
    c_stat: cover property (opc_done && rx_byte == `NVS_OP_STAT_READ);
    c_mode3: cover property (cs_fall && sck_s);
    c_full: cover property (fin.valid && !fin.ready);
endmodule : nvs_spi_top

// file: nvs_spi_master.sv
`timescale 1ns/10ps
// ============================================================
// spi master model, mode 0 or 3, half bit = 4 ref cycles, far below the rate limit
module nvs_spi_master (
    input  wire logic ref_clk,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // header left-aligned in hd, then nb copies of db; rx keeps last 8 so bits
    task automatic xfer(input logic [31:0] hd, input int hb, input int nb,
                        input logic [7:0] db, input logic m3, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        sck <= m3;
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b0;
        for (i = 0; i < hb + 8 * nb; i++) begin
            repeat (4) @(posedge ref_clk);
            // sampled late in the bit: slave only moves so after the next fall
            rx = {rx[6:0], so};
            sck <= 1'b0;
            si <= (i < hb) ? hd[31 - i] : db[7 - (i - hb) % 8];
            repeat (4) @(posedge ref_clk);
            sck <= 1'b1;
        end
        repeat (4) @(posedge ref_clk);
        rx = {rx[6:0], so};
        sck <= m3;
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge ref_clk);
    endtask : xfer
endmodule : nvs_spi_master

// file: tb_top.sv
`timescale 1ns/10ps
// ============================================================
// self-checking bench
module tb_top;
    import nvs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n, cs_n, sck, si, so, so_oe_n, bo, boe_n, power_fail, ae, sreq, areq;
    logic sbi, nv_in; // store engine busy, stored autosave copy
    logic [16:0] mem_addr, addr_last;
    logic mav, mwr, mbv, mem_byte_ready, overrun;
    nvs_byte_t mem_byte, byte_last;
    logic [7:0] rx;
    int errors = 0;
    int tests_run = 0;
    int addr_seen, pops, oe_seen, aut_seen, st_seen;
    always #20 ref_clk = ~ref_clk;
    nvs_spi_top #(.RELOAD_US(20), .RECALL_US(40)) nvs_spi_top_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .so_oe_n(so_oe_n), .store_busy_pin_o(bo), .store_busy_pin_oe_n(boe_n),
        .store_busy_in(sbi), .autosave_nv_in(nv_in), .power_fail(power_fail),
        .autosave_en(ae), .store_req(sreq), .autostore_req(areq), .mem_addr(mem_addr),
        .mem_addr_valid(mav), .mem_is_write(mwr), .mem_byte(mem_byte),
        .mem_byte_valid(mbv), .mem_byte_ready(mem_byte_ready), .overrun(overrun));
    nvs_spi_master nvs_spi_master_i (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck),
        .si(si), .so(so_oe_n ? ~so : so)); // released line shows the inverse
    // one-cycle pulses are caught here
    always @(posedge ref_clk) begin
        if (mav === 1'b1) begin
            addr_seen++;
            addr_last = mem_addr;
        end
        if (mbv === 1'b1 && mem_byte_ready === 1'b1) begin
            pops++;
            byte_last = mem_byte;
        end
        if (so_oe_n === 1'b0) oe_seen++;
        if (areq === 1'b1) aut_seen++;
        if (sreq === 1'b1) st_seen++;
    end
    task automatic end_of_test();
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [16:0] s, input logic [16:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wait_idle(input int lim);
        int k;
        for (k = 0; k < lim && boe_n !== 1'b1; k++) @(posedge ref_clk);
        chk("busy_end", k < lim, 1'b1);
        if (k >= lim) end_of_test();
    endtask : wait_idle
    task automatic op(input logic [7:0] c, input logic m3);
        nvs_spi_master_i.xfer({c, 24'h00_0000}, 8, 0, 8'h00, m3, rx);
    endtask : op
    task automatic t_powerup(input logic nv);
        nv_in <= nv;
        rst_n <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("busy_pin", boe_n, 1'b0);
        chk("busy_lvl", bo, 1'b0);
        chk("autosave_rst", ae, 1'b1);
        addr_seen = 0;
        nvs_spi_master_i.xfer(32'h0200_0010, 32, 1, 8'h11, 1'b0, rx);
        chk("reload_lock", addr_seen, 0);
        wait_idle(600);
        chk("autosave_nv", ae, nv);
    endtask : t_powerup
    task automatic t_autosave();
        aut_seen = 0;
        op(8'h19, 1'b0);
        chk("as_off", ae, 1'b0);
        power_fail <= 1'b1;
        repeat (4) @(posedge ref_clk);
        power_fail <= 1'b0;
        chk("as_skip", aut_seen, 0);
        op(8'h59, 1'b1);
        chk("as_on", ae, 1'b1);
        power_fail <= 1'b1;
        repeat (4) @(posedge ref_clk);
        power_fail <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("as_store", aut_seen, 1);
        st_seen = 0;
        op(8'h3C, 1'b0);
        chk("store_req", st_seen, 1);
        sbi <= 1'b1;
        nvs_spi_master_i.xfer(32'h0500_0000, 8, 1, 8'h00, 1'b0, rx);
        chk("stat_store", rx, 8'h01);
        sbi <= 1'b0;
    endtask : t_autosave
    task automatic t_recall();
        op(8'h60, 1'b0);
        chk("rcl_busy", boe_n, 1'b0);
        nvs_spi_master_i.xfer(32'h0500_0000, 8, 1, 8'h00, 1'b0, rx);
        chk("stat_busy", rx, 8'h01);
        chk("so_rel", so_oe_n, 1'b1);
        addr_seen = 0;
        nvs_spi_master_i.xfer(32'h0200_0020, 32, 1, 8'h22, 1'b0, rx);
        chk("rcl_lock", addr_seen, 0);
        wait_idle(1200);
        nvs_spi_master_i.xfer(32'h0500_0000, 8, 1, 8'h00, 1'b1, rx);
        chk("stat_rdy", rx, 8'h00);
    endtask : t_recall
    task automatic t_write();
        mem_byte_ready <= 1'b1;
        addr_seen = 0;
        pops = 0;
        nvs_spi_master_i.xfer(32'h02FF_5AC3, 32, 1, 8'hA5, 1'b0, rx);
        chk("addr", addr_last, 17'h1_5AC3);
        chk("addr_cnt", addr_seen, 1);
        chk("wr_byte", byte_last, 8'hA5);
        chk("wr_flag", mwr, 1'b1);
        mem_byte_ready <= 1'b0;
        pops = 0;
        // 16 in the array, one in the output stage, one waiting: the 19th is lost
        nvs_spi_master_i.xfer(32'h0200_0000, 32, 19, 8'h3C, 1'b1, rx);
        chk("overrun", overrun, 1'b1);
        mem_byte_ready <= 1'b1;
        repeat (40) @(posedge ref_clk);
        chk("drained", pops, 18);
    endtask : t_write
    task automatic t_invalid();
        oe_seen = 0;
        addr_seen = 0;
        nvs_spi_master_i.xfer(32'h1E02_0000, 16, 3, 8'h00, 1'b0, rx);
        chk("bad_so", oe_seen, 0);
        chk("bad_mem", addr_seen, 0);
    endtask : t_invalid
    initial begin
        rst_n = 1'b0;
        power_fail = 1'b0;
        sbi = 1'b0;
        mem_byte_ready = 1'b0;
        t_powerup(1'b1);
        t_autosave();
        t_recall();
        t_write();
        t_invalid();
        op(8'h19, 1'b0);
        t_powerup(1'b0);
        end_of_test();
    end
endmodule : tb_top
